// >>> shared/pfsel_consts.svh
`ifndef PFSEL_CONSTS_SVH
`define PFSEL_CONSTS_SVH
`define PFSEL_OFS_SELECT_LOW  8'h00
`define PFSEL_OFS_SELECT_HIGH 8'h04
`define PFSEL_OFS_MUX_CONFIG  8'h08
`define PFSEL_OFS_STATUS      8'h0C
`define PFSEL_RST_SELECT_LOW  32'h00000000
`define PFSEL_RST_SELECT_HIGH 32'h00000000
`define PFSEL_RST_MUX_CONFIG  2'h0
`define PFSEL_PIN0_LSB        5'h00
`define PFSEL_PIN1_LSB        5'h02
`define PFSEL_PIN2_LSB        5'h04
`define PFSEL_PIN31_LSB       5'h1E
`define PFSEL_MAP_EXT         2'h3
`define PFSEL_STAT_BLOCKED    0
`define PFSEL_STAT_RSV_LSB    1
`define PFSEL_STAT_EXT_MAP    5
`define PFSEL_HSIZE_WORD      3'h2
`define PFSEL_TRIP_IDLE       1'b1
`endif

// >>> shared/pfsel_pkg.sv
`include "pfsel_consts.svh"
package pfsel_pkg;
  typedef enum logic [1:0] {
    code_gpio = 2'b00,
    code_alt1 = 2'b01,
    code_alt2 = 2'b10,
    code_alt3 = 2'b11
  } pfsel_code_e;
  typedef enum logic [1:0] {
    bus_idle  = 2'b00,
    bus_write = 2'b01,
    bus_rwait = 2'b10,
    bus_rdata = 2'b11
  } pfsel_bus_e;
  function automatic pfsel_code_e pfsel_field(input logic [31:0] word, input logic [4:0] lsb);
    pfsel_field = pfsel_code_e'(word[lsb +: 2]);
  endfunction : pfsel_field
endpackage : pfsel_pkg

// >>> logic/pfsel_ahb_slave.sv
`timescale 1ns/1ns
`include "pfsel_consts.svh"
module pfsel_ahb_slave (
  input  wire  logic                   hclk,
  input  wire  logic                   hresetn,
  input  wire  logic                   hsel,
  input  wire  logic [31:0]            haddr,
  input  wire  logic [1:0]             htrans,
  input  wire  logic                   hwrite,
  input  wire  logic [2:0]             hsize,
  input  wire  logic                   hready,
  input  wire  logic [31:0]            rd_data,
  output logic                         hreadyout,
  output logic [31:0]                  hrdata,
  output logic                         hresp,
  output logic                         wr_en,
  output logic [7:0]                   reg_addr
);
  import pfsel_pkg::*;
  pfsel_bus_e  state_q;
  logic [7:0]  addr_q;
  logic [31:0] rdata_q;
  logic        ready_q;
  wire accept = hsel && htrans[1] && hready && (hsize == `PFSEL_HSIZE_WORD);
  assign wr_en     = (state_q == bus_write);
  assign reg_addr  = addr_q;
  assign hreadyout = ready_q;
  assign hrdata    = rdata_q;
  assign hresp     = 1'b0;
  // Reads take one wait state so a write just before them is already visible.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= bus_idle;
      addr_q  <= 8'h00;
      rdata_q <= 32'h00000000;
      ready_q <= 1'b1;
    end else if (state_q == bus_rwait) begin
      rdata_q <= rd_data;
      ready_q <= 1'b1;
      state_q <= bus_rdata;
    end else if (accept) begin
      addr_q  <= haddr[7:0];
      ready_q <= hwrite;
      state_q <= hwrite ? bus_write : bus_rwait;
    end else begin
      state_q <= bus_idle;
    end
  end
  a_read_stall: assert property (@(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
endmodule : pfsel_ahb_slave

// >>> logic/pfsel_pin_route.sv
`timescale 1ns/1ns
module pfsel_pin_route (
  input  wire  logic                   hclk,
  input  wire  logic                   hresetn,
  input  wire  pfsel_pkg::pfsel_code_e sel,
  input  wire  logic                   gpio_out,
  input  wire  logic                   gpio_oe,
  input  wire  logic [3:0]             alt_out,
  input  wire  logic [3:0]             alt_oe,
  input  wire  logic [3:0]             alt_ok,
  input  wire  logic                   pin_in,
  output logic                         pin_out_q,
  output logic                         pin_oe_q,
  output logic                         reserved_q,
  output logic                         pin_level_q
);
  import pfsel_pkg::*;
  logic [2:0] sync_q;
  wire is_gpio   = (sel == code_gpio);
  wire alt_valid = !is_gpio && alt_ok[sel];
  // A reserved code leaves the pin undriven; safer than a guessed function.
  wire out_d = is_gpio ? gpio_out : (alt_valid && alt_out[sel]); // see RL13
  wire oe_d  = is_gpio ? gpio_oe : (alt_valid && alt_oe[sel]); // see RL13
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q   <= 1'b0;
      pin_oe_q    <= 1'b0;
      reserved_q  <= 1'b0;
      sync_q      <= 3'h0;
      pin_level_q <= 1'b0;
    end else begin
      pin_out_q  <= out_d;
      pin_oe_q   <= oe_d;
      reserved_q <= !is_gpio && !alt_valid;
      sync_q     <= {sync_q[1:0], pin_in};
      if (sync_q[1] == sync_q[2]) begin
        pin_level_q <= sync_q[2];
      end
    end
  end
endmodule : pfsel_pin_route

// >>> logic/pfsel_top.sv
// Functional notes
// RL1 - Pin 2 field is bits 5:4 of low select; 00 is GPIO, reset default.
// RL2 - Pin 2 code 01 drives PWM 2 A, or PWM 3 A in extended mapping.
// RL3 - Pin 1 field is bits 3:2 of low select; 00 GPIO default, 11 reserved.
// RL4 - Pin 1 code 01 drives PWM 1 B, or PWM 2 A in extended mapping.
// RL5 - Pin 1 code 10 is serial port D data, reserved without that port.
// RL6 - Pin 0 field is bits 1:0 of low select; 00 GPIO default, 11 reserved.
// RL7 - Pin 0 PWM code always drives PWM 1 A, whatever the mapping mode.
// RL8 - High select holds sixteen 2-bit fields, pins 16 to 31, all reset zero.
// RL9 - Pin 31 is bits 31:30; 00 GPIO, 01 CAN A transmit, 10 reserved.
// RL10 - Pin 31 code 11 is trip zone 4 input on extended variant only.
// RL11 - Select registers change only while protected writes are permitted.
// RL12 - Software must avoid reserved codes; the pin is then undefined.
// RL13 - A peripheral selection takes pin value and enable from that peripheral; only serial port D supplies the enable, PWM and CAN codes force it high.
`timescale 1ns/1ns
`include "pfsel_consts.svh"
module pfsel_top #(
  parameter bit EXT_PWM_VARIANT = 1'b1,
  parameter bit HAS_SERIAL_D    = 1'b1,
  parameter bit HAS_CAN_A       = 1'b1
) (
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  input  wire  logic        protected_write_permit,
  input  wire  logic [3:0]  gpio_out,
  input  wire  logic [3:0]  gpio_oe,
  input  wire  logic        pwm1_out_a,
  input  wire  logic        pwm1_out_b,
  input  wire  logic        pwm2_out_a,
  input  wire  logic        pwm3_out_a,
  input  wire  logic        serial_d_slave_in_master_out,
  input  wire  logic        serial_d_slave_in_master_out_oe,
  input  wire  logic        can_a_transmit,
  input  wire  logic [3:0]  pin_in,
  output logic [3:0]        pin_out_q,
  output logic [3:0]        pin_oe_q,
  output logic [3:0]        gpio_in_q,
  output logic              serial_d_slave_in_master_out_rx_q,
  output logic              trip_zone_4_input_q,
  output logic [31:0]       select_low_q,
  output logic [31:0]       select_high_q
);
  import pfsel_pkg::*;

  logic        wr_en;
  logic [7:0]  reg_addr;
  logic [31:0] rd_data;
  logic [1:0]  port_mux_config_q;
  logic        blocked_q;
  logic        boot_q;
  logic [3:0]  reserved_q;
  logic [3:0]  level;
  logic [3:0]  alt_out [4];
  logic [3:0]  alt_oe  [4];
  logic [3:0]  alt_ok  [4];
  pfsel_code_e sel     [4];

  pfsel_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .rd_data   (rd_data),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .wr_en     (wr_en),
    .reg_addr  (reg_addr)
  );

  wire wr_low   = wr_en && (reg_addr == `PFSEL_OFS_SELECT_LOW);
  wire wr_high  = wr_en && (reg_addr == `PFSEL_OFS_SELECT_HIGH);
  wire wr_cfg   = wr_en && (reg_addr == `PFSEL_OFS_MUX_CONFIG);
  wire wr_stat  = wr_en && (reg_addr == `PFSEL_OFS_STATUS);
  wire prot_hit = wr_low || wr_high || wr_cfg;
  // The permit is sampled in the data phase, when the write really lands.
  wire wr_allow = prot_hit && protected_write_permit; // see RL11
  wire wr_deny  = prot_hit && !protected_write_permit; // see RL11
  wire ext_map  = EXT_PWM_VARIANT && (port_mux_config_q == `PFSEL_MAP_EXT);

  assign sel[0] = pfsel_field(select_low_q, `PFSEL_PIN0_LSB); // see RL6
  assign sel[1] = pfsel_field(select_low_q, `PFSEL_PIN1_LSB); // see RL3
  assign sel[2] = pfsel_field(select_low_q, `PFSEL_PIN2_LSB); // see RL1
  assign sel[3] = pfsel_field(select_high_q, `PFSEL_PIN31_LSB); // see RL9

  wire pin1_pwm = ext_map ? pwm2_out_a : pwm1_out_b; // see RL4
  wire pin2_pwm = ext_map ? pwm3_out_a : pwm2_out_a; // see RL2

  // Bit n of each vector belongs to selection code n; bit 0 is never used.
  assign alt_out[0] = {1'b0, 1'b0, pwm1_out_a, 1'b0}; // see RL7
  assign alt_oe[0]  = 4'h2;
  assign alt_ok[0]  = 4'h2; // see RL6
  assign alt_out[1] = {1'b0, serial_d_slave_in_master_out, pin1_pwm, 1'b0}; // see RL5
  assign alt_oe[1]  = {1'b0, serial_d_slave_in_master_out_oe, 1'b1, 1'b0}; // see RL5
  assign alt_ok[1]  = {1'b0, HAS_SERIAL_D, 1'b1, 1'b0}; // see RL3
  assign alt_out[2] = {1'b0, 1'b0, pin2_pwm, 1'b0}; // see RL2
  assign alt_oe[2]  = 4'h2;
  assign alt_ok[2]  = 4'h2;
  // Trip zone 4 is an input, so code 11 is valid on the extended variant only and never drives the pin.
  assign alt_out[3] = {1'b0, 1'b0, can_a_transmit, 1'b0}; // see RL9
  assign alt_oe[3]  = 4'h2;
  assign alt_ok[3]  = {EXT_PWM_VARIANT, 1'b0, HAS_CAN_A, 1'b0}; // see RL10

  for (genvar i = 0; i < 4; i++) begin : g_pin
    pfsel_pin_route u_route (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .sel         (sel[i]),
      .gpio_out    (gpio_out[i]),
      .gpio_oe     (gpio_oe[i]),
      .alt_out     (alt_out[i]),
      .alt_oe      (alt_oe[i]),
      .alt_ok      (alt_ok[i]),
      .pin_in      (pin_in[i]),
      .pin_out_q   (pin_out_q[i]),
      .pin_oe_q    (pin_oe_q[i]),
      .reserved_q  (reserved_q[i]),
      .pin_level_q (level[i])
    );
  end

  wire simo_sel = HAS_SERIAL_D && (sel[1] == code_alt2);
  wire trip_sel = EXT_PWM_VARIANT && (sel[3] == code_alt3);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      select_low_q <= `PFSEL_RST_SELECT_LOW; // see RL1
    end else if (wr_low && wr_allow) begin
      select_low_q <= hwdata; // see RL11
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      select_high_q <= `PFSEL_RST_SELECT_HIGH; // see RL8
    end else if (wr_high && wr_allow) begin
      select_high_q <= hwdata; // see RL8
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_mux_config_q <= `PFSEL_RST_MUX_CONFIG;
    end else if (wr_cfg && wr_allow) begin
      port_mux_config_q <= hwdata[1:0];
    end
  end

  // A refused write sets the flag even in the cycle software clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blocked_q <= 1'b0;
    end else if (wr_deny) begin
      blocked_q <= 1'b1; // see RL11
    end else if (wr_stat && hwdata[`PFSEL_STAT_BLOCKED]) begin
      blocked_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gpio_in_q                         <= 4'h0;
      serial_d_slave_in_master_out_rx_q <= 1'b0;
      trip_zone_4_input_q               <= `PFSEL_TRIP_IDLE;
      boot_q                            <= 1'b0;
    end else begin
      gpio_in_q                         <= level;
      serial_d_slave_in_master_out_rx_q <= simo_sel ? level[1] : 1'b0; // see RL5
      trip_zone_4_input_q               <= trip_sel ? level[3] : `PFSEL_TRIP_IDLE; // see RL10
      boot_q                            <= 1'b1;
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    if (reg_addr == `PFSEL_OFS_SELECT_LOW) begin
      rd_data = select_low_q;
    end else if (reg_addr == `PFSEL_OFS_SELECT_HIGH) begin
      rd_data = select_high_q;
    end else if (reg_addr == `PFSEL_OFS_MUX_CONFIG) begin
      rd_data[1:0] = port_mux_config_q;
    end else if (reg_addr == `PFSEL_OFS_STATUS) begin
      rd_data[`PFSEL_STAT_BLOCKED] = blocked_q;
      rd_data[`PFSEL_STAT_RSV_LSB +: 4] = reserved_q;
      rd_data[`PFSEL_STAT_EXT_MAP] = ext_map;
    end
  end

  a_reset_defaults: assert property (@(posedge hclk) disable iff (!hresetn) // see RL1
    !boot_q |-> (select_low_q == `PFSEL_RST_SELECT_LOW)
             && (select_high_q == `PFSEL_RST_SELECT_HIGH)
             && (sel[0] == code_gpio) && (sel[3] == code_gpio))
    else $error("select registers not zero after reset");

  a_pin0_pwm_fixed: assert property (@(posedge hclk) disable iff (!hresetn) // see RL7
    (sel[0] == code_alt1) |=> pin_out_q[0] == $past(pwm1_out_a) && pin_oe_q[0])
    else $error("pin 0 does not follow PWM 1 A");

  a_pin1_pwm_map: assert property (@(posedge hclk) disable iff (!hresetn) // see RL4
    (sel[1] == code_alt1) |=>
      pin_out_q[1] == ($past(ext_map) ? $past(pwm2_out_a) : $past(pwm1_out_b)))
    else $error("pin 1 PWM source wrong");

  a_pin2_pwm_map: assert property (@(posedge hclk) disable iff (!hresetn) // see RL2
    (sel[2] == code_alt1) |=>
      pin_out_q[2] == ($past(ext_map) ? $past(pwm3_out_a) : $past(pwm2_out_a)))
    else $error("pin 2 PWM source wrong");

  a_pin1_serial_d: assert property (@(posedge hclk) disable iff (!hresetn) // see RL5
    simo_sel |=> pin_out_q[1] == $past(serial_d_slave_in_master_out)
             && pin_oe_q[1] == $past(serial_d_slave_in_master_out_oe))
    else $error("pin 1 does not carry serial port D data");

  a_pin31_can: assert property (@(posedge hclk) disable iff (!hresetn) // see RL9
    (sel[3] == code_alt1) |=>
      pin_oe_q[3] == HAS_CAN_A && pin_out_q[3] == ($past(can_a_transmit) && HAS_CAN_A))
    else $error("pin 31 CAN transmit routing wrong");

  a_pin31_trip: assert property (@(posedge hclk) disable iff (!hresetn) // see RL10
    trip_sel |=> !pin_oe_q[3] && (trip_zone_4_input_q == $past(level[3])))
    else $error("pin 31 driven while trip zone input");

  a_write_blocked: assert property (@(posedge hclk) disable iff (!hresetn) // see RL11
    wr_deny |=> $stable(select_low_q) && $stable(select_high_q) && blocked_q)
    else $error("protected write not refused");

  a_write_taken: assert property (@(posedge hclk) disable iff (!hresetn) // see RL8
    (wr_high && protected_write_permit) |=> select_high_q == $past(hwdata))
    else $error("permitted write to high select lost");

  a_gpio_route: assert property (@(posedge hclk) disable iff (!hresetn) // see RL13
    (sel[2] == code_gpio) |=> pin_out_q[2] == $past(gpio_out[2])
                          && pin_oe_q[2] == $past(gpio_oe[2]))
    else $error("GPIO path not routed on pin 2");

  a_reserved_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // see RL6
    (sel[0] == code_alt3) |=> !pin_oe_q[0] && reserved_q[0])
    else $error("reserved pin 0 code drives the pin");

  a_pin0_code_two: assert property (@(posedge hclk) disable iff (!hresetn) // see RL6
    (sel[0] == code_alt2) |=> !pin_oe_q[0] && reserved_q[0])
    else $error("unused pin 0 code drives the pin");

  // Reserved codes leave the pad undriven, so no guessed function fights a board net.
  a_pin1_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // see RL3
    (sel[1] == code_alt3) |=> !pin_oe_q[1] && reserved_q[1])
    else $error("reserved pin 1 code drives the pin");

  a_pin2_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // see RL1
    ((sel[2] == code_alt2) || (sel[2] == code_alt3)) |=>
      !pin_oe_q[2] && reserved_q[2])
    else $error("reserved pin 2 code drives the pin");

  a_pin31_reserved: assert property (@(posedge hclk) disable iff (!hresetn) // see RL9
    (sel[3] == code_alt2) |=> !pin_oe_q[3] && reserved_q[3])
    else $error("reserved pin 31 code drives the pin");

  // Every pin, not only pin 2, must fall back to the general data and direction logic.
  a_pin0_gpio: assert property (@(posedge hclk) disable iff (!hresetn) // see RL6
    (sel[0] == code_gpio) |=> pin_out_q[0] == $past(gpio_out[0])
                          && pin_oe_q[0] == $past(gpio_oe[0]))
    else $error("GPIO path not routed on pin 0");

  a_pin1_gpio: assert property (@(posedge hclk) disable iff (!hresetn) // see RL3
    (sel[1] == code_gpio) |=> pin_out_q[1] == $past(gpio_out[1])
                          && pin_oe_q[1] == $past(gpio_oe[1]))
    else $error("GPIO path not routed on pin 1");

  a_pin31_gpio: assert property (@(posedge hclk) disable iff (!hresetn) // see RL9
    (sel[3] == code_gpio) |=> pin_out_q[3] == $past(gpio_out[3])
                          && pin_oe_q[3] == $past(gpio_oe[3]))
    else $error("GPIO path not routed on pin 31");

  a_pin1_pwm_drive: assert property (@(posedge hclk) disable iff (!hresetn) // see RL4
    (sel[1] == code_alt1) |=> pin_oe_q[1] && !reserved_q[1])
    else $error("pin 1 PWM code does not drive the pin");

  a_pin2_pwm_drive: assert property (@(posedge hclk) disable iff (!hresetn) // see RL2
    (sel[2] == code_alt1) |=> pin_oe_q[2] && !reserved_q[2])
    else $error("pin 2 PWM code does not drive the pin");

  a_trip_idle: assert property (@(posedge hclk) disable iff (!hresetn) // see RL10
    !trip_sel |=> trip_zone_4_input_q == `PFSEL_TRIP_IDLE)
    else $error("trip zone input not idle while unselected");

  a_serial_rx_level: assert property (@(posedge hclk) disable iff (!hresetn) // see RL5
    simo_sel |=> serial_d_slave_in_master_out_rx_q == $past(level[1]))
    else $error("serial port D receive does not follow pin 1");

  a_serial_rx_idle: assert property (@(posedge hclk) disable iff (!hresetn) // see RL5
    !simo_sel |=> !serial_d_slave_in_master_out_rx_q)
    else $error("serial port D receive active while unselected");

  a_ext_map_base: assert property (@(posedge hclk) disable iff (!hresetn) // see RL4
    (port_mux_config_q != `PFSEL_MAP_EXT) |-> !ext_map)
    else $error("extended mapping active in base mode");

  a_config_blocked: assert property (@(posedge hclk) disable iff (!hresetn) // see RL11
    (wr_cfg && wr_deny) |=> $stable(port_mux_config_q))
    else $error("protected config write not refused");

  a_select_hold: assert property (@(posedge hclk) disable iff (!hresetn) // see RL11
    !(wr_low && wr_allow) |=> $stable(select_low_q))
    else $error("low select changed without a permitted write");

  a_low_write_taken: assert property (@(posedge hclk) disable iff (!hresetn) // see RL11
    (wr_low && protected_write_permit) |=> select_low_q == $past(hwdata))
    else $error("permitted write to low select lost");

  a_cfg_write_taken: assert property (@(posedge hclk) disable iff (!hresetn) // see RL11
    (wr_cfg && protected_write_permit) |=> port_mux_config_q == $past(hwdata[1:0]))
    else $error("permitted write to config lost");

  a_blocked_clear: assert property (@(posedge hclk) disable iff (!hresetn) // see RL11
    (wr_stat && hwdata[`PFSEL_STAT_BLOCKED]) |=> !blocked_q)
    else $error("refused write flag not cleared");

  c_blocked_write: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_deny ##1 blocked_q);

  c_ext_pin2: cover property (@(posedge hclk) disable iff (!hresetn)
    ext_map && (sel[2] == code_alt1));

  c_serial_d: cover property (@(posedge hclk) disable iff (!hresetn)
    simo_sel ##1 pin_oe_q[1]);

  c_trip_zone: cover property (@(posedge hclk) disable iff (!hresetn)
    trip_sel ##4 !trip_zone_4_input_q);

  c_ext_pin1: cover property (@(posedge hclk) disable iff (!hresetn)
    ext_map && (sel[1] == code_alt1));
endmodule : pfsel_top

// >>> sim/tb_port_a_pin_function_select.sv
`timescale 1ns/1ns
`include "pfsel_consts.svh"
module tb_port_a_pin_function_select;
  localparam int MAX_CYCLES = 6000;
  logic        hclk, hresetn, hsel, hwrite, permit;
  logic [31:0] haddr, hwdata, hrdata, sel_lo, sel_hi;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, p1a, p1b, p2a, p3a, sdo, sdo_oe, can_tx, sd_rx, tz4;
  logic [3:0]  gpio_out, gpio_oe, pin_in, pin_out, pin_oe, gpio_in;
  wire         hready;
  int          error_cnt, num_checks;
  int          cyc = 0;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  pfsel_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .protected_write_permit(permit), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .pwm1_out_a(p1a), .pwm1_out_b(p1b), .pwm2_out_a(p2a), .pwm3_out_a(p3a),
    .serial_d_slave_in_master_out(sdo), .serial_d_slave_in_master_out_oe(sdo_oe),
    .can_a_transmit(can_tx), .pin_in(pin_in), .pin_out_q(pin_out), .pin_oe_q(pin_oe),
    .gpio_in_q(gpio_in), .serial_d_slave_in_master_out_rx_q(sd_rx),
    .trip_zone_4_input_q(tz4), .select_low_q(sel_lo), .select_high_q(sel_hi));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  // A hang would otherwise leave the run without a verdict.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc >= MAX_CYCLES) begin
      error_cnt = error_cnt + 1;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  // One single word transfer; the data phase starts only once the address is taken.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= `PFSEL_HSIZE_WORD;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h00000000;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
    logic [31:0] x;
    ahb(1'b0, a, 32'h00000000, x);
    chk(n, exp, x);
  endtask : rd

  task automatic pins(input logic [3:0] eo, input logic [3:0] eoe);
    repeat (3) @(posedge hclk);
    chk("pin_out", {28'h0000000, eo}, {28'h0000000, pin_out});
    chk("pin_oe", {28'h0000000, eoe}, {28'h0000000, pin_oe});
  endtask : pins

  task automatic t_reset;
    rd(`PFSEL_OFS_SELECT_LOW, 32'h00000000, "select_low");
    rd(`PFSEL_OFS_SELECT_HIGH, 32'h00000000, "select_high");
    pins(gpio_out, gpio_oe);
    chk("trip", 32'h00000001, {31'h0, tz4});
    $display("test reset done");
  endtask : t_reset

  task automatic t_protect;
    permit <= 1'b0;
    wr(`PFSEL_OFS_SELECT_LOW, 32'h00000015);
    wr(`PFSEL_OFS_SELECT_HIGH, 32'h40000000);
    rd(`PFSEL_OFS_SELECT_LOW, 32'h00000000, "select_low");
    rd(`PFSEL_OFS_SELECT_HIGH, 32'h00000000, "select_high");
    rd(`PFSEL_OFS_STATUS, 32'h00000001, "status");
    chk("select_low_q", 32'h00000000, sel_lo);
    chk("hresp", 32'h00000000, {31'h0, hresp});
    wr(`PFSEL_OFS_STATUS, 32'h00000001);
    rd(`PFSEL_OFS_STATUS, 32'h00000000, "status");
    permit <= 1'b1;
    $display("test protect done");
  endtask : t_protect

  task automatic t_high;
    wr(`PFSEL_OFS_SELECT_HIGH, 32'h35A5C3F0);
    rd(`PFSEL_OFS_SELECT_HIGH, 32'h35A5C3F0, "select_high");
    chk("select_high_q", 32'h35A5C3F0, sel_hi);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h00000000, "unmapped");
    rd(`PFSEL_OFS_SELECT_LOW, 32'h00000000, "select_low");
    wr(`PFSEL_OFS_SELECT_HIGH, 32'h00000000);
    $display("test high done");
  endtask : t_high

  // Each source is set opposite to the one it could be confused with.
  task automatic t_route;
    logic ext;
    logic v;
    for (int m = 0; m < 4; m++) begin
      ext = (m == 3);
      wr(`PFSEL_OFS_MUX_CONFIG, 32'(m));
      wr(`PFSEL_OFS_SELECT_LOW, 32'h00000015);
      wr(`PFSEL_OFS_SELECT_HIGH, 32'h40000000);
      rd(`PFSEL_OFS_STATUS, ext ? 32'h00000020 : 32'h00000000, "status");
      for (int k = 0; k < 2; k++) begin
        v = k[0];
        p1a <= v;
        p1b <= ~v;
        p2a <= v;
        p3a <= ~v;
        can_tx <= ~v;
        pins({~v, ext ? ~v : v, ext ? v : ~v, v}, 4'hF);
      end
    end
    wr(`PFSEL_OFS_MUX_CONFIG, 32'h00000000);
    wr(`PFSEL_OFS_SELECT_HIGH, 32'h00000000);
    $display("test route done");
  endtask : t_route

  task automatic t_serial;
    wr(`PFSEL_OFS_SELECT_LOW, 32'h00000008);
    for (int k = 0; k < 2; k++) begin
      sdo <= k[0];
      sdo_oe <= ~k[0];
      pin_in <= {2'b00, k[0], 1'b0};
      gpio_out <= 4'b0101;
      gpio_oe <= 4'b1011;
      repeat (4) @(posedge hclk);
      pins({1'b0, 1'b1, k[0], 1'b1}, {1'b1, 1'b0, ~k[0], 1'b1});
      chk("serial_rx", {31'h0, k[0]}, {31'h0, sd_rx});
    end
    wr(`PFSEL_OFS_SELECT_LOW, 32'h00000000);
    $display("test serial done");
  endtask : t_serial

  task automatic t_trip;
    wr(`PFSEL_OFS_SELECT_HIGH, 32'hC0000000);
    for (int k = 0; k < 2; k++) begin
      pin_in <= {k[0], 1'b1, 1'b0, k[0]};
      repeat (6) @(posedge hclk);
      chk("trip", {31'h0, k[0]}, {31'h0, tz4});
      chk("gpio_in", {28'h0, k[0], 2'b10, k[0]}, {28'h0, gpio_in});
      chk("pin31_oe", 32'h00000000, {31'h0, pin_oe[3]});
    end
    wr(`PFSEL_OFS_SELECT_HIGH, 32'h00000000);
    $display("test trip done");
  endtask : t_trip

  // Reserved codes are software's fault; the block still keeps the pad quiet.
  task automatic t_reserved;
    wr(`PFSEL_OFS_SELECT_LOW, 32'h0000003F);
    wr(`PFSEL_OFS_SELECT_HIGH, 32'h80000000);
    pins(4'h0, 4'h0);
    rd(`PFSEL_OFS_STATUS, 32'h0000001E, "status");
    wr(`PFSEL_OFS_SELECT_LOW, 32'h00000000);
    wr(`PFSEL_OFS_SELECT_HIGH, 32'h00000000);
    $display("test reserved done");
  endtask : t_reserved

  initial begin
    error_cnt = 0;
    num_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = `PFSEL_HSIZE_WORD;
    hwdata = 32'h00000000;
    permit = 1'b1;
    gpio_out = 4'b0110;
    gpio_oe = 4'b1010;
    {p1a, p1b, p2a, p3a, sdo, sdo_oe, can_tx} = 7'h00;
    pin_in = 4'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_protect();
    t_high();
    t_route();
    t_serial();
    t_trip();
    t_reserved();
    close_out();
  end
endmodule : tb_port_a_pin_function_select
